// ===== port_select_irq_decode_pkg.sv
// Shared constants for the four-port bus front end: address split, bit maps, reset values
package port_select_irq_decode_pkg;
    localparam int NUM_PORTS = 4;
    localparam int NUM_LEVELS = 8;
    localparam int ADDR_W = 12;
    localparam int BASE_W = 6;
    localparam int SEL_W = 5;
    localparam int DATA_SW_W = 2;

    // System interrupt level driven by routing line 0
    localparam int FIRST_IRQ_LEVEL = 8;

    // Bus address field positions, bit 11 is A3 and bit 0 is A14
    localparam int ADDR_BASE_HI = 11;
    localparam int ADDR_BASE_LO = 6;
    localparam int ADDR_GROUP_BIT = 5;
    localparam int ADDR_SEL_HI = 4;
    localparam int ADDR_SEL_LO = 0;

    // Contiguous port layout in software addresses
    localparam logic [15:0] FIRST_PORT_SW_BASE = 16'h0200;
    localparam logic [15:0] PORT_SW_STEP = 16'h0080;

    // Controller bit displacements
    localparam logic [SEL_W-1:0] BIT_RX_ERROR = 5'h09;
    localparam logic [SEL_W-1:0] BIT_DSC_IRQ_EN = 5'h11;
    localparam logic [SEL_W-1:0] BIT_RX_IRQ_EN = 5'h12;
    localparam logic [SEL_W-1:0] BIT_TX_IRQ_EN = 5'h13;
    localparam logic [SEL_W-1:0] BIT_TIMER_IRQ_EN = 5'h14;
    localparam logic [SEL_W-1:0] BIT_RX_FULL = 5'h15;
    localparam logic [SEL_W-1:0] BIT_TX_FLAG = 5'h16;
    localparam logic [SEL_W-1:0] BIT_TIMER_FLAG = 5'h17;
    localparam logic [SEL_W-1:0] BIT_DSC_FLAG = 5'h18;
    localparam logic [SEL_W-1:0] BIT_IRQ_PENDING = 5'h1f;

    // Modem group bit displacements, counted from the start of the lower half
    localparam logic [SEL_W-1:0] MBIT_LED = 5'h04;
    localparam logic [SEL_W-1:0] MBIT_DTR = 5'h05;
    localparam logic [SEL_W-1:0] MBIT_SWITCH_LO = 5'h04;
    localparam logic [SEL_W-1:0] MBIT_SWITCH_HI = 5'h05;
    localparam logic [SEL_W-1:0] MBIT_RING = 5'h06;
    localparam logic [SEL_W-1:0] MBIT_DSR = 5'h07;

    // Reset values
    localparam logic LED_OFF_N = 1'b1;
    localparam logic DTR_OFF = 1'b0;
    localparam logic [NUM_LEVELS-1:0] LEVELS_IDLE_N = 8'hff;
    localparam logic [NUM_PORTS-1:0] PORTS_IDLE_N = 4'hf;
    localparam logic [NUM_PORTS-1:0] PORTS_NONE = 4'h0;
endpackage

// ===== pin_sync.sv
// Three-stage input synchroniser that follows a bit once stages two and three agree
`timescale 1ns/10ps
module pin_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end
        else if (ce)
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= (stage3 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
        end
    end
endmodule

// ===== irq_level_router.sv
// Wired-OR of port interrupt requests onto the eight system interrupt levels
`timescale 1ns/10ps
module irq_level_router
    import port_select_irq_decode_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NUM_PORTS-1:0] req_n,
    input wire logic [NUM_PORTS-1:0][NUM_LEVELS-1:0] route,
    output logic [NUM_LEVELS-1:0] level_n
);
    logic [NUM_LEVELS-1:0] any_req;

    always_comb
    begin
        any_req = '0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (!req_n[p])
                any_req = any_req | route[p];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            level_n <= LEVELS_IDLE_N;
        else if (ce)
            level_n <= ~any_req;
    end
endmodule

// ===== port_select_irq_decode.sv
// Bus front end of the four-port serial expander: select decode, port bits, interrupt routing
`timescale 1ns/10ps
module port_select_irq_decode
    import port_select_irq_decode_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [ADDR_W-1:0] BUS_ADDR,
    input wire logic MEMORY_CYCLE_QUALIFIER_N,
    input wire logic SERIAL_BIT_OUT,
    input wire logic SERIAL_BIT_STROBE,
    input wire logic BUS_IO_RESET_N,
    input wire logic BUS_REFERENCE_CLOCK_N,
    input wire logic [NUM_PORTS-1:0][BASE_W-1:0] BASE_SWITCH,
    input wire logic [NUM_PORTS-1:0][NUM_LEVELS-1:0] IRQ_LEVEL_SWITCH,
    input wire logic [NUM_PORTS-1:0][DATA_SW_W-1:0] DATA_LEVEL_SWITCH,
    input wire logic [NUM_PORTS-1:0] RING_INDICATOR_N,
    input wire logic [NUM_PORTS-1:0] MODEM_DSR_N,
    input wire logic [NUM_PORTS-1:0] MODEM_CTS_N,
    input wire logic [NUM_PORTS-1:0] RX_CHAR_EVENT,
    input wire logic [NUM_PORTS-1:0] RX_CHAR_ERROR,
    input wire logic [NUM_PORTS-1:0] TX_MOVE_EVENT,
    input wire logic [NUM_PORTS-1:0] TIMER_ZERO_EVENT,
    output logic SERIAL_BIT_IN,
    output logic INPUT_PATH_ENABLE,
    output logic [NUM_PORTS-1:0] PORT_PRIMARY_SELECT,
    output logic [NUM_PORTS-1:0] PORT_SECONDARY_SELECT_N,
    output logic [NUM_PORTS-1:0] CTRL_SELECT_N,
    output logic [NUM_PORTS-1:0] CTRL_CLOCK,
    output logic LOCAL_PORT_CLEAR_N,
    output logic [NUM_PORTS-1:0] CTRL_IRQ_N,
    output logic [NUM_LEVELS-1:0] SYSTEM_IRQ_N,
    output logic [NUM_PORTS-1:0] MODEM_DTR,
    output logic [NUM_PORTS-1:0] PORT_LED_N
);
    localparam int PIN_W = ADDR_W + 5 + NUM_PORTS * (BASE_W + NUM_LEVELS + DATA_SW_W + 3);

    // Lowest set bit as a one-hot code
    function automatic logic [NUM_LEVELS-1:0] lowest_set(input logic [NUM_LEVELS-1:0] v);
        logic [NUM_LEVELS-1:0] r;
        r = '0;
        for (int i = NUM_LEVELS - 1; i >= 0; i--)
        begin
            if (v[i])
                r = '0;
            if (v[i])
                r[i] = 1'b1;
        end
        return r;
    endfunction

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_level;
    logic [ADDR_W-1:0] bus_addr;
    logic memory_cycle_qualifier_n;
    logic serial_bit_out;
    logic serial_bit_strobe;
    logic bus_io_reset_n;
    logic bus_reference_clock_n;
    logic [NUM_PORTS-1:0][BASE_W-1:0] base_switch;
    logic [NUM_PORTS-1:0][NUM_LEVELS-1:0] irq_switch;
    logic [NUM_PORTS-1:0][DATA_SW_W-1:0] data_switch;
    logic [NUM_PORTS-1:0] ring_indicator_n;
    logic [NUM_PORTS-1:0] dsr_n;
    logic [NUM_PORTS-1:0] cts_n;

    logic [BASE_W-1:0] addr_base;
    logic function_group_line;
    logic [SEL_W-1:0] bit_sel;
    logic [NUM_PORTS-1:0] base_match;
    logic [NUM_PORTS-1:0] port_primary_select;
    logic input_path_enable;
    logic strobe_prev;
    logic write_pulse;
    logic [NUM_PORTS-1:0] ctrl_write;
    logic [NUM_PORTS-1:0] modem_write;
    logic [NUM_PORTS-1:0] ctrl_read;
    logic [NUM_PORTS-1:0] modem_read;
    logic next_bit_in;
    logic local_port_clear_n;
    logic port_clear;
    logic [NUM_PORTS-1:0][NUM_LEVELS-1:0] irq_route;
    logic [NUM_PORTS-1:0] next_irq_n;

    assign pin_raw = {BUS_ADDR, MEMORY_CYCLE_QUALIFIER_N, SERIAL_BIT_OUT, SERIAL_BIT_STROBE,
                      BUS_IO_RESET_N, BUS_REFERENCE_CLOCK_N, BASE_SWITCH, IRQ_LEVEL_SWITCH,
                      DATA_LEVEL_SWITCH, RING_INDICATOR_N, MODEM_DSR_N, MODEM_CTS_N};

    pin_sync #(.WIDTH(PIN_W)) u_pin_sync
    (
        .clk(MCLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .pin(pin_raw),
        .level(pin_level)
    );

    assign {bus_addr, memory_cycle_qualifier_n, serial_bit_out, serial_bit_strobe,
            bus_io_reset_n, bus_reference_clock_n, base_switch, irq_switch,
            data_switch, ring_indicator_n, dsr_n, cts_n} = pin_level;

    // Address split: base field, function group, bit within group
    assign addr_base = bus_addr[ADDR_BASE_HI:ADDR_BASE_LO];
    assign function_group_line = bus_addr[ADDR_GROUP_BIT];
    assign bit_sel = bus_addr[ADDR_SEL_HI:ADDR_SEL_LO];

    // One base step in the upper field is one port step in software addresses
    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
            base_match[p] = memory_cycle_qualifier_n && (addr_base == base_switch[p]);
    end

    // Overlapping switch settings resolve to the lowest port
    assign port_primary_select = NUM_PORTS'(lowest_set({{(NUM_LEVELS - NUM_PORTS){1'b0}},
                                                         base_match}));
    assign input_path_enable = |port_primary_select;

    assign port_clear = !local_port_clear_n;
    assign write_pulse = serial_bit_strobe && !strobe_prev && memory_cycle_qualifier_n;
    assign ctrl_write = write_pulse && function_group_line ? port_primary_select : PORTS_NONE;
    assign modem_write = write_pulse && !function_group_line ? port_primary_select : PORTS_NONE;

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            strobe_prev <= 1'b0;
        else if (CLK_EN)
            strobe_prev <= serial_bit_strobe;
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            local_port_clear_n <= 1'b0;
        else if (CLK_EN)
            local_port_clear_n <= bus_io_reset_n;
    end

    assign LOCAL_PORT_CLEAR_N = local_port_clear_n;

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            CTRL_CLOCK <= PORTS_NONE;
        else if (CLK_EN)
            CTRL_CLOCK <= {NUM_PORTS{!bus_reference_clock_n}};
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            PORT_PRIMARY_SELECT <= PORTS_NONE;
            PORT_SECONDARY_SELECT_N <= PORTS_IDLE_N;
            CTRL_SELECT_N <= PORTS_IDLE_N;
        end
        else if (CLK_EN)
        begin
            PORT_PRIMARY_SELECT <= port_primary_select;
            PORT_SECONDARY_SELECT_N <= ~(port_primary_select &
                                         {NUM_PORTS{!function_group_line}});
            CTRL_SELECT_N <= ~(port_primary_select & {NUM_PORTS{function_group_line}});
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            logic rx_full;
            logic rx_error;
            logic tx_flag;
            logic timer_flag;
            logic dsc_flag;
            logic rx_irq_en;
            logic tx_irq_en;
            logic timer_irq_en;
            logic dsc_irq_en;
            logic dsr_prev;
            logic cts_prev;
            logic data_set_change;
            logic irq_pending;
            logic wr_rx_en;
            logic wr_tx_en;
            logic wr_timer_en;
            logic wr_dsc_en;

            assign wr_rx_en = ctrl_write[gp] && (bit_sel == BIT_RX_IRQ_EN);
            assign wr_tx_en = ctrl_write[gp] && (bit_sel == BIT_TX_IRQ_EN);
            assign wr_timer_en = ctrl_write[gp] && (bit_sel == BIT_TIMER_IRQ_EN);
            assign wr_dsc_en = ctrl_write[gp] && (bit_sel == BIT_DSC_IRQ_EN);
            assign data_set_change = (dsr_n[gp] != dsr_prev) || (cts_n[gp] != cts_prev);

            // Writing an enable bit also acknowledges its flag; a new event in that cycle wins
            always_ff @(posedge MCLK)
            begin
                if (SYS_RST || port_clear)
                begin
                    rx_full <= 1'b0;
                    rx_error <= 1'b0;
                    tx_flag <= 1'b0;
                    timer_flag <= 1'b0;
                    dsc_flag <= 1'b0;
                end
                else if (CLK_EN)
                begin
                    rx_full <= RX_CHAR_EVENT[gp] || (rx_full && !wr_rx_en);
                    rx_error <= (RX_CHAR_EVENT[gp] && RX_CHAR_ERROR[gp]) ||
                                (rx_error && !wr_rx_en && !RX_CHAR_EVENT[gp]);
                    tx_flag <= TX_MOVE_EVENT[gp] || (tx_flag && !wr_tx_en);
                    timer_flag <= TIMER_ZERO_EVENT[gp] || (timer_flag && !wr_timer_en);
                    dsc_flag <= data_set_change || (dsc_flag && !wr_dsc_en);
                end
            end

            always_ff @(posedge MCLK)
            begin
                if (SYS_RST || port_clear)
                begin
                    rx_irq_en <= 1'b0;
                    tx_irq_en <= 1'b0;
                    timer_irq_en <= 1'b0;
                    dsc_irq_en <= 1'b0;
                end
                else if (CLK_EN)
                begin
                    if (wr_rx_en)
                        rx_irq_en <= serial_bit_out;
                    if (wr_tx_en)
                        tx_irq_en <= serial_bit_out;
                    if (wr_timer_en)
                        timer_irq_en <= serial_bit_out;
                    if (wr_dsc_en)
                        dsc_irq_en <= serial_bit_out;
                end
            end

            always_ff @(posedge MCLK)
            begin
                if (SYS_RST)
                begin
                    dsr_prev <= 1'b0;
                    cts_prev <= 1'b0;
                end
                else if (CLK_EN)
                begin
                    dsr_prev <= dsr_n[gp];
                    cts_prev <= cts_n[gp];
                end
            end

            assign irq_pending = (rx_full && rx_irq_en) || (tx_flag && tx_irq_en) ||
                                 (timer_flag && timer_irq_en) || (dsc_flag && dsc_irq_en);
            assign next_irq_n[gp] = !irq_pending;

            always_ff @(posedge MCLK)
            begin
                if (SYS_RST || port_clear)
                begin
                    MODEM_DTR[gp] <= DTR_OFF;
                    PORT_LED_N[gp] <= LED_OFF_N;
                end
                else if (CLK_EN && modem_write[gp])
                begin
                    if (bit_sel == MBIT_DTR)
                        MODEM_DTR[gp] <= serial_bit_out;
                    if (bit_sel == MBIT_LED)
                        PORT_LED_N[gp] <= serial_bit_out;
                end
            end

            always_comb
            begin
                ctrl_read[gp] = 1'b0;
                unique case (bit_sel)
                    BIT_RX_ERROR: ctrl_read[gp] = rx_error;
                    BIT_DSC_IRQ_EN: ctrl_read[gp] = dsc_irq_en;
                    BIT_RX_IRQ_EN: ctrl_read[gp] = rx_irq_en;
                    BIT_TX_IRQ_EN: ctrl_read[gp] = tx_irq_en;
                    BIT_TIMER_IRQ_EN: ctrl_read[gp] = timer_irq_en;
                    BIT_RX_FULL: ctrl_read[gp] = rx_full;
                    BIT_TX_FLAG: ctrl_read[gp] = tx_flag;
                    BIT_TIMER_FLAG: ctrl_read[gp] = timer_flag;
                    BIT_DSC_FLAG: ctrl_read[gp] = dsc_flag;
                    BIT_IRQ_PENDING: ctrl_read[gp] = irq_pending;
                    default: ctrl_read[gp] = 1'b0;
                endcase
            end

            always_comb
            begin
                modem_read[gp] = 1'b0;
                unique case (bit_sel)
                    MBIT_SWITCH_LO: modem_read[gp] = data_switch[gp][0];
                    MBIT_SWITCH_HI: modem_read[gp] = data_switch[gp][1];
                    MBIT_RING: modem_read[gp] = !ring_indicator_n[gp];
                    MBIT_DSR: modem_read[gp] = !dsr_n[gp];
                    default: modem_read[gp] = 1'b0;
                endcase
            end

            assign irq_route[gp] = lowest_set(irq_switch[gp]);
        end
    endgenerate

    always_comb
    begin
        next_bit_in = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (port_primary_select[p])
                next_bit_in = function_group_line ? ctrl_read[p] : modem_read[p];
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            SERIAL_BIT_IN <= 1'b0;
            INPUT_PATH_ENABLE <= 1'b0;
        end
        else if (CLK_EN)
        begin
            SERIAL_BIT_IN <= next_bit_in && input_path_enable;
            INPUT_PATH_ENABLE <= input_path_enable;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            CTRL_IRQ_N <= PORTS_IDLE_N;
        else if (CLK_EN)
            CTRL_IRQ_N <= next_irq_n;
    end

    irq_level_router u_irq_level_router
    (
        .clk(MCLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .req_n(CTRL_IRQ_N),
        .route(irq_route),
        .level_n(SYSTEM_IRQ_N)
    );
endmodule

// ===== port_select_irq_decode_monitor.sv
// Concurrent checks on the ports of the bus front end
`timescale 1ns/10ps
module port_select_irq_decode_monitor
    import port_select_irq_decode_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic MEMORY_CYCLE_QUALIFIER_N,
    input wire logic BUS_IO_RESET_N,
    input wire logic BUS_REFERENCE_CLOCK_N,
    input wire logic SERIAL_BIT_IN,
    input wire logic INPUT_PATH_ENABLE,
    input wire logic [NUM_PORTS-1:0] PORT_PRIMARY_SELECT,
    input wire logic [NUM_PORTS-1:0] PORT_SECONDARY_SELECT_N,
    input wire logic [NUM_PORTS-1:0] CTRL_SELECT_N,
    input wire logic [NUM_PORTS-1:0] CTRL_CLOCK,
    input wire logic LOCAL_PORT_CLEAR_N,
    input wire logic [NUM_PORTS-1:0] CTRL_IRQ_N,
    input wire logic [NUM_LEVELS-1:0] SYSTEM_IRQ_N,
    input wire logic [NUM_PORTS-1:0] MODEM_DTR,
    input wire logic [NUM_PORTS-1:0] PORT_LED_N
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // Long enough for a pin level to cross the synchroniser and the output stage
    sequence memory_cycle_held;
        !MEMORY_CYCLE_QUALIFIER_N [*7];
    endsequence
    sequence bus_reset_held;
        !BUS_IO_RESET_N [*7];
    endsequence
    a_one_port_only: assert property ($onehot0(PORT_PRIMARY_SELECT))
        else $error("more than one port selected");
    a_secondary_needs_primary: assert property (
        ((~PORT_SECONDARY_SELECT_N | ~CTRL_SELECT_N) & ~PORT_PRIMARY_SELECT) == 4'h0)
        else $error("secondary select without primary select");
    a_group_exclusive: assert property ((~PORT_SECONDARY_SELECT_N & ~CTRL_SELECT_N) == 4'h0)
        else $error("controller and modem group selected together");
    a_enable_tracks_select: assert property (INPUT_PATH_ENABLE == (|PORT_PRIMARY_SELECT))
        else $error("input path enable differs from port selection");
    a_read_released: assert property (!INPUT_PATH_ENABLE |-> !SERIAL_BIT_IN)
        else $error("read bit driven with no port selected");
    a_memory_no_select: assert property (
        memory_cycle_held |-> PORT_PRIMARY_SELECT == 4'h0 && !INPUT_PATH_ENABLE)
        else $error("port selected during memory cycle");
    a_clear_follows_reset: assert property (bus_reset_held |-> !LOCAL_PORT_CLEAR_N)
        else $error("local clear not asserted under bus reset");
    a_clear_empties_latches: assert property (
        !LOCAL_PORT_CLEAR_N [*2] |-> MODEM_DTR == 4'h0 && PORT_LED_N == 4'hf)
        else $error("port latches not cleared by local clear");
    a_clock_follows_ref: assert property (!BUS_REFERENCE_CLOCK_N [*7] |-> CTRL_CLOCK == 4'hf)
        else $error("controller clock does not follow reference clock");
    a_clocks_equal: assert property (CTRL_CLOCK == 4'h0 || CTRL_CLOCK == 4'hf)
        else $error("controller clocks differ");
    a_level_has_source: assert property (
        SYSTEM_IRQ_N != 8'hff |-> $past(CTRL_IRQ_N) != 4'hf)
        else $error("system level low with no port request");
endmodule
bind port_select_irq_decode port_select_irq_decode_monitor mon_u (.MCLK, .SYS_RST,
    .MEMORY_CYCLE_QUALIFIER_N, .BUS_IO_RESET_N, .BUS_REFERENCE_CLOCK_N, .SERIAL_BIT_IN,
    .INPUT_PATH_ENABLE, .PORT_PRIMARY_SELECT, .PORT_SECONDARY_SELECT_N, .CTRL_SELECT_N,
    .CTRL_CLOCK, .LOCAL_PORT_CLEAR_N, .CTRL_IRQ_N, .SYSTEM_IRQ_N, .MODEM_DTR, .PORT_LED_N);

// ===== bus_master_model.sv
// Processor-side model of the bit-serial I/O bus
`timescale 1ns/10ps
module bus_master_model
    import port_select_irq_decode_pkg::*;
(
    input wire logic clk,
    input wire logic bit_in,
    input wire logic in_en,
    input wire logic [NUM_LEVELS-1:0] irq_n,
    output logic [ADDR_W-1:0] addr,
    output logic mem_n,
    output logic bit_out,
    output logic strobe
);
    logic [NUM_LEVELS-1:0] mask = 8'h01;
    logic irq_seen;
    assign irq_seen = |(~irq_n & mask);
    initial
    begin
        addr = 12'h000;
        mem_n = 1'b1;
        bit_out = 1'b0;
        strobe = 1'b0;
    end
    task automatic put_addr(input logic [ADDR_W-1:0] a, input logic m);
        @(posedge clk);
        addr <= a;
        mem_n <= m;
        repeat (8) @(posedge clk);
    endtask
    // Address and data held across the whole strobe, strobe low long enough after
    task automatic write_bit(input logic [ADDR_W-1:0] a, input logic d);
        @(posedge clk);
        addr <= a;
        mem_n <= 1'b1;
        bit_out <= d;
        repeat (6) @(posedge clk);
        strobe <= 1'b1;
        repeat (6) @(posedge clk);
        strobe <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // A released read line floats high on the bus side
    task automatic read_bit(input logic [ADDR_W-1:0] a, output logic d);
        put_addr(a, 1'b1);
        d = in_en ? bit_in : 1'b1;
    endtask
endmodule

// ===== tb_top.sv
// Self-checking testbench of the bus front end
`timescale 1ns/10ps
module tb_top;
    import port_select_irq_decode_pkg::*;
    typedef struct packed {logic [11:0] a; logic m; logic [3:0] p;
                           logic [3:0] s; logic [3:0] c;} row_t;
    row_t rows [7] = '{'{12'h120, 1'b1, 4'h1, 4'hf, 4'he}, '{12'h144, 1'b1, 4'h2, 4'hd, 4'hf},
        '{12'h1bf, 1'b1, 4'h4, 4'hf, 4'hb}, '{12'h1c7, 1'b1, 4'h8, 4'h7, 4'hf},
        '{12'hfe0, 1'b1, 4'h0, 4'hf, 4'hf}, '{12'h0e0, 1'b1, 4'h0, 4'hf, 4'hf},
        '{12'h120, 1'b0, 4'h0, 4'hf, 4'hf}};
    logic [4:0] en_bit [3] = '{BIT_TX_IRQ_EN, BIT_TIMER_IRQ_EN, BIT_DSC_IRQ_EN};
    logic mclk = 1'b0, sys_rst = 1'b1, io_rst_n = 1'b1, ref_n = 1'b1, mem_n, bit_out, strobe;
    logic [11:0] addr;
    logic [3:0][5:0] base_sw = {6'h07, 6'h06, 6'h05, 6'h04};
    logic [3:0][7:0] irq_sw = {8'h80, 8'h04, 8'h01, 8'h01};
    logic [3:0][1:0] data_sw = {2'b00, 2'b01, 2'b11, 2'b10};
    logic [3:0] ring_n = 4'h7, dsr_n = 4'hf, cts_n = 4'hf, rx_ev = 4'h0, rx_err = 4'h0;
    logic [3:0] tx_ev = 4'h0, tm_ev = 4'h0, prim, sec_n, ctl_n, cclk, cirq_n, dtr, led_n;
    logic bit_in, in_en, clr_n, d;
    logic [7:0] sys_n;
    int n_mismatch = 0, compares = 0;
    always #2.5 mclk = ~mclk;
    always
    begin
        repeat (8) @(posedge mclk);
        ref_n <= ~ref_n;
    end
    port_select_irq_decode dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .BUS_ADDR(addr),
        .MEMORY_CYCLE_QUALIFIER_N(mem_n), .SERIAL_BIT_OUT(bit_out), .SERIAL_BIT_STROBE(strobe),
        .BUS_IO_RESET_N(io_rst_n), .BUS_REFERENCE_CLOCK_N(ref_n), .BASE_SWITCH(base_sw),
        .IRQ_LEVEL_SWITCH(irq_sw), .DATA_LEVEL_SWITCH(data_sw), .RING_INDICATOR_N(ring_n),
        .MODEM_DSR_N(dsr_n), .MODEM_CTS_N(cts_n), .RX_CHAR_EVENT(rx_ev), .RX_CHAR_ERROR(rx_err),
        .TX_MOVE_EVENT(tx_ev), .TIMER_ZERO_EVENT(tm_ev), .SERIAL_BIT_IN(bit_in),
        .INPUT_PATH_ENABLE(in_en), .PORT_PRIMARY_SELECT(prim), .PORT_SECONDARY_SELECT_N(sec_n),
        .CTRL_SELECT_N(ctl_n), .CTRL_CLOCK(cclk), .LOCAL_PORT_CLEAR_N(clr_n),
        .CTRL_IRQ_N(cirq_n), .SYSTEM_IRQ_N(sys_n), .MODEM_DTR(dtr), .PORT_LED_N(led_n));
    bus_master_model bus_u (.clk(mclk), .bit_in(bit_in), .in_en(in_en), .irq_n(sys_n),
        .addr(addr), .mem_n(mem_n), .bit_out(bit_out), .strobe(strobe));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [11:0] ad(input int p, input logic g, input logic [4:0] b);
        return {6'(4 + p), g, b};
    endfunction
    // Kind 0 rx, 1 tx, 2 timer, 3 modem status change, on port p
    task automatic fire(input int k, input int p);
        @(posedge mclk);
        case (k)
            0: rx_ev[p] <= 1'b1;
            1: tx_ev[p] <= 1'b1;
            2: tm_ev[p] <= 1'b1;
            default: cts_n[p] <= ~cts_n[p];
        endcase
        @(posedge mclk);
        rx_ev <= 4'h0;
        tx_ev <= 4'h0;
        tm_ev <= 4'h0;
        repeat (10) @(posedge mclk);
    endtask
    task automatic close_out();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge mclk);
        check(8'(dtr), 8'h00);
        check(8'(led_n), 8'h0f);
        check(sys_n, 8'hff);
        foreach (rows[i])
        begin
            bus_u.put_addr(rows[i].a, rows[i].m);
            check(8'(prim), 8'(rows[i].p));
            check(8'(sec_n), 8'(rows[i].s));
            check(8'(ctl_n), 8'(rows[i].c));
            check(8'(in_en), 8'(|rows[i].p));
        end
        // Software addresses count two per bit
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            bus_u.put_addr(12'((FIRST_PORT_SW_BASE + PORT_SW_STEP * p) >> 1), 1'b1);
            check(8'(prim), 8'(1 << p));
        end
        bus_u.write_bit(ad(1, 1'b0, MBIT_DTR), 1'b1);
        check(8'(dtr), 8'h02);
        bus_u.write_bit(ad(2, 1'b0, MBIT_LED), 1'b0);
        check(8'(led_n), 8'h0b);
        bus_u.read_bit(ad(3, 1'b0, MBIT_RING), d);
        check(8'(d), 8'h01);
        bus_u.read_bit(ad(0, 1'b0, MBIT_DSR), d);
        check(8'(d), 8'h00);
        bus_u.read_bit(ad(0, 1'b0, MBIT_SWITCH_HI), d);
        check(8'(d), 8'h01);
        bus_u.read_bit(ad(0, 1'b0, MBIT_SWITCH_LO), d);
        check(8'(d), 8'h00);
        fire(0, 0);
        check(8'(cirq_n), 8'h0f);
        bus_u.read_bit(ad(0, 1'b1, BIT_RX_FULL), d);
        check(8'(d), 8'h01);
        bus_u.write_bit(ad(0, 1'b1, BIT_RX_IRQ_EN), 1'b1);
        fire(0, 0);
        check(8'(cirq_n), 8'h0e);
        check(sys_n, 8'hfe);
        check(8'(bus_u.irq_seen), 8'h01);
        bus_u.read_bit(ad(0, 1'b1, BIT_IRQ_PENDING), d);
        check(8'(d), 8'h01);
        bus_u.read_bit(ad(1, 1'b1, BIT_IRQ_PENDING), d);
        check(8'(d), 8'h00);
        bus_u.write_bit(ad(1, 1'b1, BIT_RX_IRQ_EN), 1'b1);
        fire(0, 1);
        check(8'(cirq_n), 8'h0c);
        bus_u.write_bit(ad(0, 1'b1, BIT_RX_IRQ_EN), 1'b1);
        check(8'(cirq_n), 8'h0d);
        check(sys_n, 8'hfe);
        bus_u.write_bit(ad(1, 1'b1, BIT_RX_IRQ_EN), 1'b1);
        check(sys_n, 8'hff);
        bus_u.read_bit(ad(0, 1'b1, BIT_RX_IRQ_EN), d);
        check(8'(d), 8'h01);
        bus_u.read_bit(ad(0, 1'b1, BIT_TX_IRQ_EN), d);
        check(8'(d), 8'h00);
        @(posedge mclk);
        rx_err <= 4'h4;
        fire(0, 2);
        rx_err <= 4'h0;
        bus_u.read_bit(ad(2, 1'b1, BIT_RX_ERROR), d);
        check(8'(d), 8'h01);
        for (int k = 1; k < 4; k++)
        begin
            bus_u.write_bit(ad(3, 1'b1, en_bit[k-1]), 1'b1);
            fire(k, 3);
            check(sys_n, 8'h7f);
            bus_u.write_bit(ad(3, 1'b1, en_bit[k-1]), 1'b0);
            check(sys_n, 8'hff);
        end
        @(posedge mclk);
        io_rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        check(8'(clr_n), 8'h00);
        check(8'(dtr), 8'h00);
        check(8'(led_n), 8'h0f);
        io_rst_n <= 1'b1;
        repeat (10) @(posedge mclk);
        check(8'(clr_n), 8'h01);
        close_out();
    end
endmodule
